// ===== rtl/sss_pkg.sv
/*
 * Shared constants of the supply supervisor event control block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz APB clock.
 */
package sss_pkg;
  // Timing
  localparam int SSS_CLK_PERIOD_NS = 10;
  localparam int SSS_MASK_TIME_NS = 2000; // Fast-mode masking delay, 2 us
  localparam int SSS_NORM_TIME_NS = 20000; // Normal-mode settling delay, 20 us
  localparam int SSS_MASK_CYC = (SSS_MASK_TIME_NS + SSS_CLK_PERIOD_NS - 1) / SSS_CLK_PERIOD_NS;
  localparam int SSS_NORM_CYC = (SSS_NORM_TIME_NS + SSS_CLK_PERIOD_NS - 1) / SSS_CLK_PERIOD_NS;
  localparam int SSS_CNT_W = 12;
  localparam int SSS_PUC_HOLD = 3; // Cycles the delays stay idle after a soft clear

  // Register byte offsets
  localparam logic [11:0] SSS_OFS_CTRL = 12'h000;
  localparam logic [11:0] SSS_OFS_STAT = 12'h004;
  localparam logic [11:0] SSS_OFS_MASK = 12'h008;
  localparam logic [11:0] SSS_OFS_INFO = 12'h00C;

  // Control fields, per side: base bit of high side 0, low side 8
  localparam int SSS_SIDE_STRIDE = 8;
  localparam int SSS_F_ENABLE = 0;
  localparam int SSS_F_FAST = 1;
  localparam int SSS_F_RSTEN = 2;
  localparam int SSS_F_KEEP = 3;

  // Info register fields
  localparam int SSS_I_FNEN = 0;
  localparam int SSS_I_MASK = 2;
  localparam int SSS_I_DONE = 4;
  localparam int SSS_I_COMP = 6;
  localparam int SSS_I_HIZ = 8;

  // Reset values: both supervisors enabled, normal mode, no reset, keep-on 0
  localparam logic [1:0] SSS_RST_ENABLE = 2'h3;
  localparam logic [1:0] SSS_RST_ZERO = 2'h0;
  localparam logic [1:0] SSS_ALL_SIDES = 2'h3;
endpackage

// ===== rtl/sss_sync2.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/1ps
module sss_sync2 #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sss_sync2

// ===== rtl/sss_delay.sv
/*
 * Settling / masking delay of one supervisor comparator.
 * Assumes comp_on is a registered level from the same clock.
 */
`timescale 1ns/1ps
module sss_delay
  import sss_pkg::*;
#(
  parameter int MASK_CYC = SSS_MASK_CYC,
  parameter int NORM_CYC = SSS_NORM_CYC,
  parameter int CW = SSS_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic comp_on,
  input wire logic fast_mode,
  input wire logic skip_start,
  output logic mask_active,
  output logic delay_done
);
  logic on_prev_q;
  logic [CW-1:0] cnt_q;

  // Refuse counts that the counter cannot hold
  if (MASK_CYC < 1 || NORM_CYC < 1 ||
      MASK_CYC >= 2**CW || NORM_CYC >= 2**CW) begin : g_bad_cnt
    $error("sss_delay: delay counts do not fit the counter");
  end

  // Reset value 1: after reset the comparator counts as already on,
  // so no settling delay is started (known hazard kept on purpose)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) on_prev_q <= 1'b1;
    else on_prev_q <= comp_on;
  end

  // Load on switch-on, run down to zero, drop when switched off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!comp_on || skip_start) begin
      cnt_q <= '0;
    end else if (!on_prev_q) begin
      cnt_q <= fast_mode ? CW'(MASK_CYC) : CW'(NORM_CYC);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  // The load cycle masks too, else one unmasked cycle leaks a trip
  assign mask_active = (cnt_q != '0) || (comp_on && !on_prev_q && !skip_start);
  assign delay_done = comp_on && !mask_active;
endmodule // sss_delay

// ===== rtl/sss_supervisor_ctrl.sv
/*
 * Supply supervisor event control: APB registers, comparator power
 * gating in low-power modes, masking delays, event flags, reset
 * requests, I/O tri-state and interrupt.
 * Assumes trip inputs are asynchronous comparator levels, lpm_active
 * and soft_puc come from logic on pclk, and por_req_q is fed back by
 * the reset controller as a power-on reset on presetn.
 */
// The register offsets and the APB interface to the registers were decided locally.
// Functional notes
// - In fast mode a 2 us event-masking delay follows each comparator switch-on outside the soft clear window.
// - A trip sets that side's event flag and, with reset enable set, raises a power-on reset.
// - While event flags are set all I/O are tri-stated until the comparators settle.
// - With keep-on at 0 the comparators are off in low-power modes two to four.
// - After soft clear or power-on reset the supervisors are on but no delay is started.
// - Switch-on in fast mode may still give a false flag as settling outlasts the mask.
// - A supervisor disabled before a soft clear leaves its flag function disabled after it.
// - After a soft clear any write to the control register restores the flag function.
`timescale 1ns/1ps
module sss_supervisor_ctrl
  import sss_pkg::*;
#(
  parameter int MASK_CYC = SSS_MASK_CYC,
  parameter int NORM_CYC = SSS_NORM_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] trip_in,
  input wire logic lpm_active,
  input wire logic soft_puc,
  output logic [1:0] comp_en_q,
  output logic por_req_q,
  output logic gpio_hiz_q,
  output logic irq_q
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0] en_q, fast_q, rsten_q, keep_q;
  logic [1:0] flag_q, irq_mask_q, fn_en_q;
  logic [1:0] trip_s, comp_on, mask_act, dly_done, flag_set;
  logic acc, wr, rd, ctrl_wr, stat_wr, mask_wr, mapped;
  logic [31:0] rdata;
  logic [SSS_PUC_HOLD-1:0] puc_sh_q;
  logic puc_hold;

  // Shortest fast mask must cover the eight-cycle mask check below
  if (MASK_CYC < 8 || NORM_CYC < MASK_CYC) begin : g_bad_delay
    $error("sss_supervisor_ctrl: delay counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, pready from a flop
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = (paddr == SSS_OFS_CTRL) || (paddr == SSS_OFS_STAT) ||
                  (paddr == SSS_OFS_MASK) || (paddr == SSS_OFS_INFO);
  assign ctrl_wr = wr && (paddr == SSS_OFS_CTRL);
  assign stat_wr = wr && (paddr == SSS_OFS_STAT);
  assign mask_wr = wr && (paddr == SSS_OFS_MASK);

  // Ready and error rise together in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata = '0;
    case (paddr)
      SSS_OFS_CTRL: begin
        for (int s = 0; s < 2; s++) begin
          rdata[s*SSS_SIDE_STRIDE+SSS_F_ENABLE] = en_q[s];
          rdata[s*SSS_SIDE_STRIDE+SSS_F_FAST] = fast_q[s];
          rdata[s*SSS_SIDE_STRIDE+SSS_F_RSTEN] = rsten_q[s];
          rdata[s*SSS_SIDE_STRIDE+SSS_F_KEEP] = keep_q[s];
        end
      end
      SSS_OFS_STAT: rdata[1:0] = flag_q;
      SSS_OFS_MASK: rdata[1:0] = irq_mask_q;
      SSS_OFS_INFO: begin
        rdata[SSS_I_FNEN +: 2] = fn_en_q;
        rdata[SSS_I_MASK +: 2] = mask_act;
        rdata[SSS_I_DONE +: 2] = dly_done;
        rdata[SSS_I_COMP +: 2] = comp_en_q;
        rdata[SSS_I_HIZ] = gpio_hiz_q;
      end
      default: rdata = '0;
    endcase
  end

  // Read data captured when pready rises, held afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (psel && penable && !pready && !pwrite) prdata <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; soft clear re-enables both supervisors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= SSS_RST_ENABLE;
      fast_q <= SSS_RST_ZERO;
      rsten_q <= SSS_RST_ZERO;
      keep_q <= SSS_RST_ZERO;
    end else if (soft_puc) begin
      en_q <= SSS_RST_ENABLE;
      fast_q <= SSS_RST_ZERO;
      rsten_q <= SSS_RST_ZERO;
      keep_q <= SSS_RST_ZERO;
    end else if (ctrl_wr) begin
      for (int s = 0; s < 2; s++) begin
        en_q[s] <= pwdata[s*SSS_SIDE_STRIDE+SSS_F_ENABLE];
        fast_q[s] <= pwdata[s*SSS_SIDE_STRIDE+SSS_F_FAST];
        rsten_q[s] <= pwdata[s*SSS_SIDE_STRIDE+SSS_F_RSTEN];
        keep_q[s] <= pwdata[s*SSS_SIDE_STRIDE+SSS_F_KEEP];
      end
    end
  end

  // Flag function: lost over a soft clear if the side was off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fn_en_q <= SSS_ALL_SIDES;
    else if (ctrl_wr) fn_en_q <= SSS_ALL_SIDES;
    else if (soft_puc) fn_en_q <= fn_en_q & en_q;
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_mask_q <= SSS_RST_ZERO;
    else if (mask_wr) irq_mask_q <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparator power: off in low-power modes unless kept on
  assign comp_on = en_q & ~({2{lpm_active}} & ~keep_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) comp_en_q <= SSS_RST_ENABLE;
    else comp_en_q <= comp_on;
  end

  // Soft clear window: a side switched on by the clear starts no
  // settling delay; an lpm wake-up inside the window starts none either
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) puc_sh_q <= '0;
    else puc_sh_q <= {puc_sh_q[SSS_PUC_HOLD-2:0], soft_puc};
  end
  assign puc_hold = |puc_sh_q;

  // Trip levels arrive from the analogue side
  sss_sync2 #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(trip_in),
    .sync_out(trip_s)
  );

  // One delay per side; a long normal-mode delay also masks
  for (genvar s = 0; s < 2; s++) begin : g_side
    sss_delay #(.MASK_CYC(MASK_CYC), .NORM_CYC(NORM_CYC)) u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .comp_on(comp_en_q[s]),
      .fast_mode(fast_q[s]),
      .skip_start(puc_hold),
      .mask_active(mask_act[s]),
      .delay_done(dly_done[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Event flags: a trip only counts outside the mask. A fast-mode
  // comparator may still be unsettled when the 2 us mask ends, so a
  // false flag can appear; that is the documented hazard, not fixed.
  assign flag_set = trip_s & comp_en_q & ~mask_act & fn_en_q;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= SSS_RST_ZERO;
    else flag_q <= (flag_q & ~(stat_wr ? pwdata[1:0] : SSS_RST_ZERO)) | flag_set;
  end

  // Supervisor power-on reset request; the mask also blocks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_req_q <= 1'b0;
    else por_req_q <= |(flag_set & rsten_q);
  end

  // I/O float while a flag stands and a comparator still trips
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gpio_hiz_q <= 1'b0;
    else gpio_hiz_q <= (|flag_set) || ((|flag_q) && (|(trip_s | mask_act)));
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else irq_q <= |(flag_q & irq_mask_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  localparam int AST_MASK_MAX = MASK_CYC;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fast_on0;
    !comp_en_q[0] ##1 comp_en_q[0] && fast_q[0];
  endsequence
  sequence s_mask_run0;
    mask_act[0] [*8] ##[1:AST_MASK_MAX] !mask_act[0];
  endsequence
  sequence s_fast_on1;
    !comp_en_q[1] ##1 comp_en_q[1] && fast_q[1];
  endsequence
  sequence s_mask_run1;
    mask_act[1] [*8] ##[1:AST_MASK_MAX] !mask_act[1];
  endsequence
  sequence s_trip_ok1;
    trip_s[1] && comp_en_q[1] && !mask_act[1] && fn_en_q[1];
  endsequence
  sequence s_puc_off1;
    soft_puc && !en_q[1] && !lpm_active;
  endsequence

  AST_MASK_START: assert property (s_fast_on0 |=> s_mask_run0)
    else $error("masking delay did not run after fast switch-on");
  AST_MASK_END: assert property (s_fast_on0 |-> ##(AST_MASK_MAX + 1) !mask_act[0])
    else $error("masking delay too long");
  AST_NO_FLAG_MASKED: assert property ($rose(flag_q[1]) |-> $past(!mask_act[1]))
    else $error("flag set during masking delay");
  AST_FLAG_SET: assert property (trip_s[0] && comp_en_q[0] && !mask_act[0] && fn_en_q[0]
                                 |=> flag_q[0])
    else $error("trip did not set flag");
  AST_POR: assert property (flag_set[1] && rsten_q[1] |=> por_req_q)
    else $error("no reset request on trip");
  AST_NO_POR: assert property (por_req_q |-> $past(|(flag_set & rsten_q)))
    else $error("reset request without cause");
  AST_HIZ: assert property ((|flag_q) && (|trip_s) |=> gpio_hiz_q)
    else $error("I/O not tri-stated with flag set");
  AST_LPM_OFF: assert property (lpm_active && !keep_q[0] |=> !comp_en_q[0])
    else $error("comparator not off in low-power mode");
  AST_PUC_FN: assert property (soft_puc && !en_q[1] && !ctrl_wr |=> !fn_en_q[1])
    else $error("flag function survived soft clear while off");
  AST_W_RESTORE: assert property (ctrl_wr |=> fn_en_q == SSS_ALL_SIDES)
    else $error("control write did not restore flag function");
  AST_PUC_NOMASK: assert property (soft_puc && comp_en_q[0] |=> ##1 !mask_act[0])
    else $error("soft clear started a delay");

  // Low side masking and soft clear
  AST_MASK_START1: assert property (s_fast_on1 |=> s_mask_run1)
    else $error("low side masking delay did not run");
  AST_MASK_END1: assert property (s_fast_on1 |-> ##(AST_MASK_MAX + 1) !mask_act[1])
    else $error("low side masking delay too long");
  AST_PUC_NODLY: assert property (s_puc_off1 |=> !mask_act[1] [*4])
    else $error("side enabled by soft clear started a delay");

  // Flags, reset requests, tri-state and interrupt
  AST_FLAG_SET1: assert property (s_trip_ok1 |=> flag_q[1])
    else $error("low side trip did not set flag");
  AST_POR0: assert property (flag_set[0] && rsten_q[0] |=> por_req_q)
    else $error("no reset request on high side trip");
  AST_FLAG_STICKY: assert property (flag_q[0] && !(stat_wr && pwdata[0]) |=> flag_q[0])
    else $error("flag dropped without a clear");
  AST_W1C: assert property (stat_wr && pwdata[1] && !flag_set[1] |=> !flag_q[1])
    else $error("write one did not clear flag");
  AST_NO_FLAG_OFF: assert property ($rose(flag_q[0]) |-> $past(comp_en_q[0] && fn_en_q[0]))
    else $error("flag set with comparator off or function disabled");
  AST_HIZ_SET: assert property ((|flag_set) |=> gpio_hiz_q)
    else $error("I/O not tri-stated on new flag");
  AST_IRQ_ON: assert property ((|(flag_q & irq_mask_q)) |=> irq_q)
    else $error("interrupt missing");
  AST_IRQ_OFF: assert property (!(|(flag_q & irq_mask_q)) |=> !irq_q)
    else $error("interrupt without unmasked flag");
  AST_INT_MASK_W: assert property (mask_wr |=> irq_mask_q == $past(pwdata[1:0]))
    else $error("mask write lost");

  // Power gating, control and bus
  AST_LPM_OFF1: assert property (lpm_active && !keep_q[1] |=> !comp_en_q[1])
    else $error("low side comparator not off in low-power mode");
  AST_LPM_KEEP: assert property (lpm_active && keep_q[0] && en_q[0] |=> comp_en_q[0])
    else $error("kept comparator switched off");
  AST_COMP_OFF_EN: assert property (!en_q[0] |=> !comp_en_q[0])
    else $error("comparator on while disabled");
  AST_PUC_CTRL: assert property (soft_puc |=> en_q == SSS_RST_ENABLE && rsten_q == SSS_RST_ZERO)
    else $error("soft clear did not reset control");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // sss_supervisor_ctrl

// ===== tb/sss_supervisor_ctrl_bench.sv
/* Self-checking bench for sss_supervisor_ctrl: APB master, trips, sleep, soft clear.
   Assumes sss_pkg and shortened delay counts of 10 and 20 cycles. */
`timescale 1ns/1ps
module sss_supervisor_ctrl_bench
  import sss_pkg::*;
;
  localparam int MC = 10;
  localparam int NC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lpm_active, soft_puc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_q, rd_v;
  logic [1:0] trip_in, comp_en_q, m;
  logic por_req_q, gpio_hiz_q, irq_q, err_v;
  int n_errors, tests_run, por_cnt, p0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset pulse counter, watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (por_req_q === 1'b1) por_cnt++;
  // Whole run is about 400 cycles; fifty times that means a hang
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  sss_supervisor_ctrl #(.MASK_CYC(MC), .NORM_CYC(NC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_in(trip_in), .lpm_active(lpm_active), .soft_puc(soft_puc), .comp_en_q(comp_en_q),
    .por_req_q(por_req_q), .gpio_hiz_q(gpio_hiz_q), .irq_q(irq_q));

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] lfsr_f(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] ctrl_f(input logic [1:0] en, fa, rs, kp);
    logic [31:0] w;
    w = 32'h0;
    for (int s = 0; s < 2; s++) begin
      w[SSS_SIDE_STRIDE*s+SSS_F_ENABLE] = en[s];
      w[SSS_SIDE_STRIDE*s+SSS_F_FAST] = fa[s];
      w[SSS_SIDE_STRIDE*s+SSS_F_RSTEN] = rs[s];
      w[SSS_SIDE_STRIDE*s+SSS_F_KEEP] = kp[s];
    end
    return w;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("pready", 32'h1, 32'h0);
      stop_test();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_v);
    chk({nm, "_err"}, 32'h0, 32'(err_v));
  endtask
  task automatic trip(input logic [1:0] v, input int c);
    @(posedge pclk);
    trip_in <= v;
    repeat (c) @(posedge pclk);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, lpm_active, soft_puc} = 6'h0;
    {paddr, pwdata, trip_in} = 46'h0;
    lfsr_q = 32'hA4C0EDA3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("comp_en", 32'h3, 32'(comp_en_q));
    rd(SSS_OFS_CTRL, 32'h101, "ctrl");
    rd(SSS_OFS_MASK, 32'h0, "mask");
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err_v));
    // Trip straight after reset: no settling delay masks it
    trip(2'h1, 5);
    rd(SSS_OFS_STAT, 32'h1, "flag");
    chk("hiz", 32'h1, 32'(gpio_hiz_q));
    chk("por_off", 32'h0, 32'(por_cnt));
    trip(2'h0, 5);
    chk("hiz_rel", 32'h0, 32'(gpio_hiz_q));
    apb(1'b1, SSS_OFS_STAT, 32'h3);
    rd(SSS_OFS_STAT, 32'h0, "w1c");
    // Reset enable turns trips into reset requests
    apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h3, 2'h0, 2'h3, 2'h0));
    p0 = por_cnt;
    trip(2'h2, 6);
    trip(2'h0, 4);
    chk("por_on", 32'h1, 32'(por_cnt > p0));
    rd(SSS_OFS_STAT, 32'h2, "flag_lo");
    // Random interrupt masks and partial clears
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_f(lfsr_q);
      m = lfsr_q[1:0];
      apb(1'b1, SSS_OFS_MASK, 32'(m));
      trip(2'h3, 5);
      trip(2'h0, 4);
      chk("irq", 32'(|m), 32'(irq_q));
      apb(1'b1, SSS_OFS_STAT, 32'(lfsr_q[3:2]));
      repeat (2) @(posedge pclk);
      chk("irq_clr", 32'(|(m & ~lfsr_q[3:2])), 32'(irq_q));
      apb(1'b1, SSS_OFS_STAT, 32'h3);
    end
    // Masking delay after switch-on, fast then normal
    apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h3, 2'h0, 2'h0, 2'h0));
    for (int f = 1; f >= 0; f--) begin
      apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h2, 2'h0, 2'h0, 2'h0));
      trip(2'h1, 5);
      apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h3, 2'(f), 2'h0, 2'(f)));
      rd(SSS_OFS_STAT, 32'h0, "masked");
      repeat ((f != 0 ? MC : NC) + 6) @(posedge pclk);
      rd(SSS_OFS_STAT, 32'h1, "unmasked");
      trip(2'h0, 4);
      apb(1'b1, SSS_OFS_STAT, 32'h3);
    end
    // Comparators in sleep with keep-on clear and set
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h3, 2'h0, 2'h0, 2'(k * 3)));
      @(posedge pclk);
      lpm_active <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("lpm_en", 32'(k * 3), 32'(comp_en_q));
      lpm_active <= 1'b0;
      repeat (NC + 6) @(posedge pclk);
      chk("wake_en", 32'h3, 32'(comp_en_q));
    end
    // Soft clear with low side off, then restore by a control write
    apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h1, 2'h0, 2'h0, 2'h0));
    @(posedge pclk);
    soft_puc <= 1'b1;
    @(posedge pclk);
    soft_puc <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("puc_en", 32'h3, 32'(comp_en_q));
    apb(1'b0, SSS_OFS_INFO, 32'h0);
    chk("fn_off", 32'h1, 32'(rd_v[SSS_I_FNEN+:2]));
    trip(2'h2, 6);
    rd(SSS_OFS_STAT, 32'h0, "no_flag");
    trip(2'h0, 4);
    apb(1'b1, SSS_OFS_CTRL, ctrl_f(2'h3, 2'h0, 2'h0, 2'h0));
    trip(2'h2, 6);
    rd(SSS_OFS_STAT, 32'h2, "restored");
    stop_test();
  end
endmodule // sss_supervisor_ctrl_bench
